// *** inc/ssg_map.vh ***
// Behaviour
// - Set-latch opcode sets latch at deselect.
// - Completed array or status write clears latch.
// - Write to protected location clears latch.
// - Clear-latch opcode clears latch immediately.
// - Deselect during hold clears latch, aborts.
// - Latch is clear after reset.
// - Status byte layout fixed, bit 7 reserved.
// - Bit 6 one disables automatic backup.
// - Bit 5 zero wraps writes within page.
// - Bit 4 read-only secure-write failure flag.
// - Protect level selects read-only address range.
// - While busy only status read executes.
// - Status-read opcode shifts status byte out.
// - Status byte refreshed at each byte boundary.
// - Status write keeps failure and busy flags.
// - Commands accepted right after status write.
// - Read opcode, 16-bit address, then data out.
// - Read address increments, wraps at array end.
// - Deselect ends read without side effects.
// - Sample on rising, drive on falling, MSB first.
`ifndef SSG_MAP_VH
`define SSG_MAP_VH

// Opcodes.
`define SSG_OP_SET_PERMIT   8'h06
`define SSG_OP_CLR_PERMIT   8'h04
`define SSG_OP_STATUS_WR    8'h01
`define SSG_OP_STATUS_RD    8'h05
`define SSG_OP_READ         8'h03
`define SSG_OP_WRITE        8'h02

// Status register field positions.
`define SSG_ST_AUTO_DIS     6
`define SSG_ST_PAGE_OVR     5
`define SSG_ST_BP_HI        3
`define SSG_ST_BP_LO        2

// Protect levels and the upper address bits they guard.
`define SSG_BP_NONE         2'h0
`define SSG_BP_QUARTER      2'h1
`define SSG_BP_HALF         2'h2
`define SSG_QUARTER_TOP     2'h3

// Geometry and reset values.
`define SSG_ADDR_W          15
`define SSG_PAGE_BITS       6
`define SSG_BIT_LAST        3'h7
`define SSG_FIFO_DEPTH      8
`define SSG_FIFO_AW         3
`define SSG_STATUS_RST      1'b0

`endif

// *** design/ssg_guard.v ***
`timescale 1ns/100ps
`default_nettype none
`include "ssg_map.vh"

// ****************************************************************
// Write buffer between serial front end and array write port
// ****************************************************************
module ssg_fifo
#(
    parameter W  = 23,
    parameter D  = `SSG_FIFO_DEPTH,
    parameter AW = `SSG_FIFO_AW
)
(
    input  wire         clk,
    input  wire         rstn,
    input  wire         in_valid,
    output wire         in_ready,
    input  wire [W-1:0] in_data,
    output wire         out_valid,
    input  wire         out_ready,
    output wire [W-1:0] out_data
);
    reg  [W-1:0] mem_q [0:D-1];
    reg  [AW:0]  wp_q;
    reg  [AW:0]  rp_q;
    wire         full;
    wire         empty;
    wire         push;
    wire         pop;

    // Pointers carry one extra bit to tell full from empty.
    assign full      = (wp_q[AW] != rp_q[AW]) && (wp_q[AW-1:0] == rp_q[AW-1:0]);
    assign empty     = (wp_q == rp_q);
    assign in_ready  = ~full;
    assign out_valid = ~empty;
    assign out_data  = mem_q[rp_q[AW-1:0]];
    assign push      = in_valid & ~full;
    assign pop       = out_ready & ~empty;

    // Pointer update.
    always @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            wp_q <= {(AW+1){1'b0}};
            rp_q <= {(AW+1){1'b0}};
        end
        else
        begin
            if (push)
                wp_q <= wp_q + 1'b1;
            if (pop)
                rp_q <= rp_q + 1'b1;
        end
    end

    // Storage entries, one per slot.
    genvar gi;
    generate
        for (gi = 0; gi < D; gi = gi + 1)
        begin : g_slot
            always @(posedge clk)
            begin
                if (push && (wp_q[AW-1:0] == gi))
                    mem_q[gi] <= in_data;
            end
        end
    endgenerate
endmodule // ssg_fifo

// ****************************************************************
// Serial command interpreter with write latch and status register
// ****************************************************************
module ssg_guard
#(
    parameter AW = `SSG_ADDR_W
)
(
    input  wire          clk,
    input  wire          rstn,
    input  wire          spi_sck,
    input  wire          spi_cs_n,
    input  wire          spi_si,
    input  wire          spi_hold_n,
    output wire          spi_so,
    output wire          spi_so_oe,
    input  wire          backup_busy,
    input  wire          secure_fail_set,
    input  wire          secure_fail_clr,
    output wire [AW-1:0] mem_raddr,
    input  wire [7:0]    mem_rdata,
    output wire          mem_wvalid,
    input  wire          mem_wready,
    output wire [AW-1:0] mem_waddr,
    output wire [7:0]    mem_wdata,
    output wire          wr_overflow,
    output wire          auto_backup_disable,
    output wire          page_wrap_override,
    output wire [1:0]    block_protect_level,
    output wire [7:0]    device_status_control
);
    localparam [2:0] ST_IDLE = 3'h0;
    localparam [2:0] ST_OP   = 3'h1;
    localparam [2:0] ST_ADDR = 3'h2;
    localparam [2:0] ST_RDAT = 3'h3;
    localparam [2:0] ST_SRD  = 3'h4;
    localparam [2:0] ST_SWR  = 3'h5;
    localparam [2:0] ST_WDAT = 3'h6;
    localparam [2:0] ST_IGN  = 3'h7;

    // Two-stage synchronisers plus one history stage for edges.
    reg  [1:0]    sck_s_q;
    reg  [1:0]    cs_s_q;
    reg  [1:0]    si_s_q;
    reg  [1:0]    hold_s_q;
    reg  [1:0]    busy_s_q;
    reg           sck_h_q;
    reg           cs_h_q;

    reg  [2:0]    state_q;
    reg  [2:0]    bitcnt_q;
    reg  [6:0]    in_sh_q;
    reg  [7:0]    out_sh_q;
    reg           so_q;
    reg           oe_q;
    reg           addr_hi_q;
    reg           is_wr_q;
    reg  [15:0]   addr_q;
    reg           held_q;
    reg           pend_set_q;
    reg           wrote_q;
    reg           ovf_q;

    reg           permit_q;
    reg           auto_dis_q;
    reg           page_ovr_q;
    reg           fail_q;
    reg  [1:0]    bp_q;

    wire          sck_rise;
    wire          sck_fall;
    wire          cs_act;
    wire          cs_rise;
    wire          byte_done;
    wire [7:0]    rx_byte;
    wire [7:0]    status;
    wire          prot_hit;
    wire [AW-1:0] waddr_cur;
    wire [AW-1:0] waddr_nxt;
    wire          fifo_ready;
    wire          push;

    // Synchronise every pin before use.
    always @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            sck_s_q  <= 2'h0;
            cs_s_q   <= 2'h3;
            si_s_q   <= 2'h0;
            hold_s_q <= 2'h3;
            busy_s_q <= 2'h0;
            sck_h_q  <= 1'b0;
            cs_h_q   <= 1'b1;
        end
        else
        begin
            sck_s_q  <= {sck_s_q[0], spi_sck};
            cs_s_q   <= {cs_s_q[0], spi_cs_n};
            si_s_q   <= {si_s_q[0], spi_si};
            hold_s_q <= {hold_s_q[0], spi_hold_n};
            busy_s_q <= {busy_s_q[0], backup_busy};
            sck_h_q  <= sck_s_q[1];
            cs_h_q   <= cs_s_q[1];
        end
    end

    // Edge detection works on the second stage only.
    assign cs_act    = ~cs_s_q[1];
    assign cs_rise   = cs_s_q[1] & ~cs_h_q;
    assign sck_rise  = cs_act & ~held_q & sck_s_q[1] & ~sck_h_q;
    assign sck_fall  = cs_act & ~held_q & ~sck_s_q[1] & sck_h_q;
    assign byte_done = sck_rise && (bitcnt_q == `SSG_BIT_LAST);
    assign rx_byte   = {in_sh_q, si_s_q[1]};

    // Status byte as read back; bit 7 always reads zero.
    assign status = {1'b0, auto_dis_q, page_ovr_q, fail_q, bp_q,
                     permit_q, busy_s_q[1]};

    // Protected range check against the current write address.
    assign waddr_cur = addr_q[AW-1:0];
    assign prot_hit  = (bp_q == `SSG_BP_NONE)    ? 1'b0 :
                       (bp_q == `SSG_BP_QUARTER) ?
                           (waddr_cur[AW-1:AW-2] == `SSG_QUARTER_TOP) :
                       (bp_q == `SSG_BP_HALF)    ? waddr_cur[AW-1] :
                       1'b1;

    // Next write address: wrap inside the page unless overridden.
    assign waddr_nxt = page_ovr_q ? waddr_cur + 1'b1 :
                       {waddr_cur[AW-1:`SSG_PAGE_BITS],
                        waddr_cur[`SSG_PAGE_BITS-1:0] + 1'b1};

    assign push = (state_q == ST_WDAT) && byte_done && !prot_hit && fifo_ready;

    // Hold is taken or released only while the clock is low; deselect releases it at once.
    always @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            held_q <= 1'b0;
        else if (!cs_act)
            held_q <= 1'b0;
        else if (!sck_s_q[1])
            held_q <= ~hold_s_q[1];
    end

    // Receive shifter and bit counter.
    always @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            bitcnt_q <= 3'h0;
            in_sh_q  <= 7'h00;
        end
        else if (!cs_act)
            bitcnt_q <= 3'h0;
        else if (sck_rise)
        begin
            bitcnt_q <= bitcnt_q + 1'b1;
            in_sh_q  <= rx_byte[6:0];
        end
    end

    // Command sequencer, address counter and write latch.
    always @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            state_q    <= ST_IDLE;
            addr_hi_q  <= 1'b0;
            is_wr_q    <= 1'b0;
            addr_q     <= 16'h0000;
            pend_set_q <= 1'b0;
            wrote_q    <= 1'b0;
            permit_q   <= `SSG_STATUS_RST;
            auto_dis_q <= `SSG_STATUS_RST;
            page_ovr_q <= `SSG_STATUS_RST;
            bp_q       <= `SSG_BP_NONE;
            ovf_q      <= 1'b0;
        end
        else if (cs_rise)
        begin
            // Frame end: apply the latch effects of the frame.
            state_q    <= ST_IDLE;
            pend_set_q <= 1'b0;
            wrote_q    <= 1'b0;
            if (held_q)
                permit_q <= 1'b0;
            else if (wrote_q)
                permit_q <= 1'b0;
            else if (pend_set_q)
                permit_q <= 1'b1;
        end
        else if (!cs_act)
            state_q <= ST_IDLE;
        else
        begin
            if (state_q == ST_IDLE)
                state_q <= ST_OP;
            else if (byte_done)
            begin
                case (state_q)
                    ST_OP:
                    begin
                        state_q   <= ST_IGN;
                        addr_hi_q <= 1'b0;
                        if (rx_byte == `SSG_OP_STATUS_RD)
                            state_q <= ST_SRD;
                        else if (busy_s_q[1])
                            state_q <= ST_IGN;
                        else if (rx_byte == `SSG_OP_SET_PERMIT)
                            pend_set_q <= 1'b1;
                        else if (rx_byte == `SSG_OP_CLR_PERMIT)
                            permit_q <= 1'b0;
                        else if (rx_byte == `SSG_OP_READ)
                        begin
                            state_q <= ST_ADDR;
                            is_wr_q <= 1'b0;
                        end
                        else if ((rx_byte == `SSG_OP_WRITE) && permit_q)
                        begin
                            state_q <= ST_ADDR;
                            is_wr_q <= 1'b1;
                        end
                        else if ((rx_byte == `SSG_OP_STATUS_WR) && permit_q)
                            state_q <= ST_SWR;
                    end
                    ST_ADDR:
                    begin
                        addr_hi_q <= 1'b1;
                        if (!addr_hi_q)
                            addr_q[15:8] <= rx_byte;
                        else
                        begin
                            addr_q[7:0] <= rx_byte;
                            state_q     <= is_wr_q ? ST_WDAT : ST_RDAT;
                        end
                    end
                    ST_RDAT:
                        addr_q <= {1'b0, waddr_cur + 1'b1};
                    ST_SWR:
                    begin
                        // Writable fields load and the write latch clears.
                        auto_dis_q <= rx_byte[`SSG_ST_AUTO_DIS];
                        page_ovr_q <= rx_byte[`SSG_ST_PAGE_OVR];
                        bp_q       <= rx_byte[`SSG_ST_BP_HI:`SSG_ST_BP_LO];
                        permit_q   <= 1'b0;
                        state_q    <= ST_IGN;
                    end
                    ST_WDAT:
                    begin
                        if (prot_hit)
                        begin
                            permit_q <= 1'b0;
                            state_q  <= ST_IGN;
                        end
                        else
                        begin
                            wrote_q <= 1'b1;
                            addr_q  <= {1'b0, waddr_nxt};
                            if (!fifo_ready)
                                ovf_q <= 1'b1;
                        end
                    end
                    default:
                        state_q <= state_q;
                endcase
            end
        end
    end

    // The failure flag is owned by the secure-write engine; set wins.
    always @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            fail_q <= 1'b0;
        else if (secure_fail_set)
            fail_q <= 1'b1;
        else if (secure_fail_clr)
            fail_q <= 1'b0;
    end

    // Transmit shifter: a fresh byte at each byte boundary.
    always @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            out_sh_q <= 8'h00;
            so_q     <= 1'b0;
            oe_q     <= 1'b0;
        end
        else if (!cs_act)
            oe_q <= 1'b0;
        else if (held_q)
            oe_q <= 1'b0;
        else if (sck_fall && ((state_q == ST_SRD) || (state_q == ST_RDAT)))
        begin
            oe_q <= 1'b1;
            if (bitcnt_q == 3'h0)
            begin
                out_sh_q <= (state_q == ST_SRD) ? status : mem_rdata;
                so_q     <= (state_q == ST_SRD) ? status[7] : mem_rdata[7];
            end
            else
            begin
                out_sh_q <= {out_sh_q[6:0], 1'b0};
                so_q     <= out_sh_q[6];
            end
        end
        else if ((state_q != ST_SRD) && (state_q != ST_RDAT))
            oe_q <= 1'b0;
    end

    // Accepted write bytes queue toward the array port.
    ssg_fifo #(
        .W  (AW + 8),
        .D  (`SSG_FIFO_DEPTH),
        .AW (`SSG_FIFO_AW)
    ) u_fifo (
        .clk       (clk),
        .rstn      (rstn),
        .in_valid  (push),
        .in_ready  (fifo_ready),
        .in_data   ({waddr_cur, rx_byte}),
        .out_valid (mem_wvalid),
        .out_ready (mem_wready),
        .out_data  ({mem_waddr, mem_wdata})
    );

    // Output assignments.
    assign spi_so                = so_q;
    assign spi_so_oe             = oe_q & cs_act & ~held_q;
    assign mem_raddr             = waddr_cur;
    assign wr_overflow           = ovf_q;
    assign auto_backup_disable   = auto_dis_q;
    assign page_wrap_override    = page_ovr_q;
    assign block_protect_level   = bp_q;
    assign device_status_control = status;
endmodule // ssg_guard

`default_nettype wire

// *** sim/ssg_guard_sva.sv ***
`timescale 1ns/100ps
`default_nettype none
// ******************************
// Port checks of the interpreter
// ******************************
module ssg_guard_sva
#(
    parameter AW = 15
)
(
    input wire logic          clk,
    input wire logic          rstn,
    input wire logic          spi_sck,
    input wire logic          spi_cs_n,
    input wire logic          spi_hold_n,
    input wire logic          spi_so,
    input wire logic          spi_so_oe,
    input wire logic          backup_busy,
    input wire logic          secure_fail_set,
    input wire logic          secure_fail_clr,
    input wire logic          mem_wvalid,
    input wire logic          mem_wready,
    input wire logic [AW-1:0] mem_waddr,
    input wire logic [7:0]    mem_wdata,
    input wire logic          wr_overflow,
    input wire logic          auto_backup_disable,
    input wire logic          page_wrap_override,
    input wire logic [1:0]    block_protect_level,
    input wire logic [7:0]    device_status_control
);
    // All checks run on the system clock and rest during reset.
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rstn);

    a_oe_deselect: assert property ($rose(spi_cs_n) |-> ##[1:5] !spi_so_oe)
        else $error("serial output still driven after deselect");
    a_so_sck_high: assert property (spi_sck [*4] |-> $stable(spi_so))
        else $error("serial output moved while serial clock high");
    a_latch_set: assert property ($rose(device_status_control[1]) |-> spi_cs_n && $past(spi_cs_n))
        else $error("write latch set before deselect");
    a_hold_abort: assert property (!spi_hold_n && $rose(spi_cs_n) |-> ##[2:6] !device_status_control[1])
        else $error("write latch kept after hold abort");
    a_status_layout: assert property (device_status_control[7] == 1'b0
        && device_status_control[6:5] == {auto_backup_disable, page_wrap_override}
        && device_status_control[3:2] == block_protect_level)
        else $error("status byte fields disagree with outputs");
    a_busy_mirror: assert property ($stable(backup_busy) [*5] |-> device_status_control[0] == backup_busy)
        else $error("busy bit does not follow backup activity");
    a_fail_set: assert property (secure_fail_set |-> ##[1:2] device_status_control[4])
        else $error("failure flag not set");
    a_fail_clr: assert property (secure_fail_clr && !secure_fail_set |-> ##[1:2] !device_status_control[4])
        else $error("failure flag not cleared");
    a_fail_keep: assert property ((!secure_fail_set && !secure_fail_clr) [*3] |-> $stable(device_status_control[4]))
        else $error("failure flag changed without cause");
    a_cfg_in_frame: assert property ($changed({auto_backup_disable, page_wrap_override, block_protect_level}) |-> !spi_cs_n)
        else $error("writable status bits changed outside a frame");
    a_wr_stall: assert property (mem_wvalid && !mem_wready |=> mem_wvalid && $stable({mem_waddr, mem_wdata}))
        else $error("write entry changed while stalled");
    a_ovf_sticky: assert property (wr_overflow |=> wr_overflow)
        else $error("overflow flag dropped");
endmodule // ssg_guard_sva

bind ssg_guard ssg_guard_sva #(.AW(AW)) u_sva (
    .clk(clk), .rstn(rstn), .spi_sck(spi_sck), .spi_cs_n(spi_cs_n), .spi_hold_n(spi_hold_n),
    .spi_so(spi_so), .spi_so_oe(spi_so_oe), .backup_busy(backup_busy),
    .secure_fail_set(secure_fail_set), .secure_fail_clr(secure_fail_clr),
    .mem_wvalid(mem_wvalid), .mem_wready(mem_wready), .mem_waddr(mem_waddr),
    .mem_wdata(mem_wdata), .wr_overflow(wr_overflow), .auto_backup_disable(auto_backup_disable),
    .page_wrap_override(page_wrap_override), .block_protect_level(block_protect_level),
    .device_status_control(device_status_control)
);
`default_nettype wire

// *** sim/ssg_spi_host.sv ***
`timescale 1ns/100ps
`default_nettype none
// ******************************
// Serial host model, clock mode 0
// ******************************
module ssg_spi_host
(
    input  wire logic clk,
    output var logic  spi_sck,
    output var logic  spi_cs_n,
    output var logic  spi_si,
    output var logic  spi_hold_n,
    input  wire logic spi_so,
    input  wire logic spi_so_oe
);
    logic        oe_seen;
    logic [95:0] sh;

    // Idle bus: deselected, clock parked low.
    initial
    begin
        spi_sck = 1'b0;
        spi_cs_n = 1'b1;
        spi_si = 1'b0;
        spi_hold_n = 1'b1;
        oe_seen = 1'b0;
    end

    // Pins move on falling system clock edges only.
    task automatic wait_fall(input int n);
        repeat (n) @(negedge clk);
    endtask

    // One bit: data set while clock low, output sampled just before the rise.
    task automatic send_bit(input logic b);
        spi_si = b;
        wait_fall(4);
        sh = {sh[94:0], spi_so_oe & spi_so};
        oe_seen = oe_seen | spi_so_oe;
        spi_sck = 1'b1;
        wait_fall(4);
        spi_sck = 1'b0;
    endtask

    // Whole frame of n bits, most significant first; the data line is inverted once released.
    task automatic xfer(input int n, input logic [95:0] tx, output logic [95:0] rx);
        sh = '0;
        oe_seen = 1'b0;
        wait_fall(4);
        spi_cs_n = 1'b0;
        for (int i = n - 1; i >= 0; i--)
            send_bit(tx[i]);
        wait_fall(4);
        spi_cs_n = 1'b1;
        spi_si = ~spi_si;
        wait_fall(6);
        rx = sh;
    endtask

    // Half an opcode, then deselect while hold is still low.
    task automatic hold_abort(input logic [7:0] op);
        wait_fall(4);
        spi_cs_n = 1'b0;
        for (int i = 7; i >= 4; i--)
            send_bit(op[i]);
        spi_hold_n = 1'b0;
        wait_fall(4);
        spi_cs_n = 1'b1;
        wait_fall(8);
        spi_hold_n = 1'b1;
        spi_si = ~spi_si;
    endtask
endmodule // ssg_spi_host
`default_nettype wire

// *** sim/tb_spi_sram_write_guard_status.sv ***
`timescale 1ns/100ps
`default_nettype none
// ******************************
// Self-checking bench
// ******************************
module tb_spi_sram_write_guard_status;
    logic        clk, rstn, spi_sck, spi_cs_n, spi_si, spi_hold_n, spi_so, spi_so_oe;
    logic        backup_busy, secure_fail_set, secure_fail_clr, mem_wvalid, wr_overflow;
    logic        auto_backup_disable, page_wrap_override, m_ovf, rdy_en;
    logic        mem_wready = 1'b0;
    logic [14:0] mem_raddr, mem_waddr;
    logic [7:0]  mem_rdata, mem_wdata, device_status_control, m_st;
    logic [1:0]  block_protect_level;
    logic [95:0] rx;
    logic [22:0] exp_q[$];
    logic [14:0] tbl[6] = '{15'h0000, 15'h3fff, 15'h4000, 15'h5fff, 15'h6000, 15'h7fff};
    int          mismatches, total_checks;

    ssg_guard u_dut (.clk(clk), .rstn(rstn), .spi_sck(spi_sck), .spi_cs_n(spi_cs_n),
        .spi_si(spi_si), .spi_hold_n(spi_hold_n), .spi_so(spi_so), .spi_so_oe(spi_so_oe),
        .backup_busy(backup_busy), .secure_fail_set(secure_fail_set),
        .secure_fail_clr(secure_fail_clr), .mem_raddr(mem_raddr), .mem_rdata(mem_rdata),
        .mem_wvalid(mem_wvalid), .mem_wready(mem_wready), .mem_waddr(mem_waddr),
        .mem_wdata(mem_wdata), .wr_overflow(wr_overflow),
        .auto_backup_disable(auto_backup_disable), .page_wrap_override(page_wrap_override),
        .block_protect_level(block_protect_level), .device_status_control(device_status_control));
    ssg_spi_host u_host (.clk(clk), .spi_sck(spi_sck), .spi_cs_n(spi_cs_n), .spi_si(spi_si),
        .spi_hold_n(spi_hold_n), .spi_so(spi_so), .spi_so_oe(spi_so_oe));

    // Array content is a fixed pattern of the address.
    function automatic logic [7:0] pat(input logic [14:0] a);
        return a[7:0] ^ {1'b0, a[14:8]} ^ 8'h5a;
    endfunction
    assign mem_rdata = pat(mem_raddr);

    function automatic logic prot(input logic [1:0] lv, input logic [14:0] a);
        return lv == 2'h3 || (lv == 2'h2 && a[14]) || (lv == 2'h1 && a[14:13] == 2'h3);
    endfunction

    task automatic chk_byte(input logic [7:0] e, input logic [7:0] g);
        total_checks++;
        if (g !== e)
        begin
            mismatches++;
            $display("ERROR t=%0t exp=%h got=%h", $time, e, g);
        end
    endtask

    task automatic chk_entry(input logic [22:0] e, input logic [22:0] g);
        total_checks++;
        if (g !== e)
        begin
            mismatches++;
            $display("ERROR t=%0t exp=%h got=%h", $time, e, g);
        end
    endtask

    task automatic final_report();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    task automatic op(input logic [7:0] o);
        u_host.xfer(8, {88'h0, o}, rx);
        if (!m_st[0] && o == 8'h06)
            m_st[1] = 1'b1;
        if (!m_st[0] && o == 8'h04)
            m_st[1] = 1'b0;
        chk_byte(m_st, device_status_control);
    endtask

    task automatic st_wr(input logic [7:0] v);
        u_host.xfer(16, {80'h0, 8'h01, v}, rx);
        if (m_st[1] && !m_st[0])
            m_st = {1'b0, v[6:5], m_st[4], v[3:2], 1'b0, m_st[0]};
        chk_byte(m_st, device_status_control);
        chk_byte({m_st[6:5], m_st[3:2], 4'h0},
            {auto_backup_disable, page_wrap_override, block_protect_level, 4'h0});
    endtask

    task automatic wr(input logic [14:0] a, input int nb);
        logic [95:0] tx;
        logic [7:0]  d;
        logic        go;
        tx = {72'h0, 8'h02, 1'b0, a};
        go = m_st[1] && !m_st[0];
        for (int k = 0; k < nb; k++)
        begin
            d = 8'($urandom);
            tx = {tx[87:0], d};
            if (go && prot(m_st[3:2], a))
                go = 1'b0;
            else if (go && exp_q.size() < 8)
                exp_q.push_back({a, d});
            else if (go)
                m_ovf = 1'b1;
            a = m_st[5] ? a + 15'h1 : {a[14:6], a[5:0] + 6'h1};
        end
        if (!m_st[0])
            m_st[1] = 1'b0;
        u_host.xfer(24 + 8 * nb, tx, rx);
        chk_byte(m_st, device_status_control);
    endtask

    task automatic rd(input logic [14:0] a, input int nb);
        u_host.xfer(24 + 8 * nb, {72'h0, 8'h03, 1'b0, a} << (8 * nb), rx);
        for (int k = 0; k < nb; k++)
            chk_byte(m_st[0] ? 8'h0 : pat(15'(a + k)), rx[8 * (nb - 1 - k) +: 8]);
    endtask

    task automatic pulse_fail(input logic set);
        @(negedge clk);
        secure_fail_set = set;
        secure_fail_clr = !set;
        @(negedge clk);
        secure_fail_set = 1'b0;
        secure_fail_clr = 1'b0;
        m_st[4] = set;
    endtask

    // System clock, 25 MHz.
    initial
    begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    // Array side accepts entries at random while enabled.
    always @(negedge clk)
        mem_wready <= rdy_en && ($urandom % 4 != 0);

    // Accepted entries must match the model's queue in order.
    always @(posedge clk)
        if (mem_wvalid && mem_wready)
            chk_entry(exp_q.size() > 0 ? exp_q.pop_front() : 23'h7fffff, {mem_waddr, mem_wdata});

    // Guard against a hung run.
    initial
    begin
        repeat (60000) @(posedge clk);
        mismatches++;
        final_report();
    end

    // Main sequence.
    initial
    begin
        rstn = 1'b0;
        backup_busy = 1'b0;
        secure_fail_set = 1'b0;
        secure_fail_clr = 1'b0;
        rdy_en = 1'b1;
        m_st = 8'h0;
        m_ovf = 1'b0;
        void'($urandom(99));
        repeat (10) @(negedge clk);
        rstn = 1'b1;
        chk_byte(8'h0, device_status_control);
        $display("test reset done");
        pulse_fail(1'b1);
        st_wr(8'hff);
        op(8'h06);
        st_wr(8'hff);
        op(8'h06);
        op(8'h04);
        pulse_fail(1'b0);
        $display("test status write done");
        fork
            u_host.xfer(24, {72'h0, 8'h05, 16'h0}, rx);
            begin
                repeat (110) @(negedge clk);
                pulse_fail(1'b1);
            end
        join
        chk_byte(m_st & 8'hef, rx[15:8]);
        chk_byte(m_st, rx[7:0]);
        $display("test status read done");
        for (int lv = 0; lv < 4; lv++)
        begin
            op(8'h06);
            st_wr({2'h0, lv[0], 1'h0, 2'(lv), 2'h0});
            for (int k = 0; k < 6; k++)
            begin
                op(8'h06);
                wr(tbl[k], 2);
            end
        end
        op(8'h06);
        st_wr(8'h00);
        wr(15'h0100, 1);
        repeat (40) @(negedge clk);
        chk_byte(8'h0, 8'(exp_q.size()));
        $display("test protection done");
        rd(15'h7ffe, 3);
        $display("test read done");
        rdy_en = 1'b0;
        op(8'h06);
        wr(15'h003c, 9);
        chk_byte({7'h0, m_ovf}, {7'h0, wr_overflow});
        rdy_en = 1'b1;
        repeat (100) @(negedge clk);
        chk_byte(8'h0, 8'(exp_q.size()));
        $display("test buffer done");
        backup_busy = 1'b1;
        m_st[0] = 1'b1;
        op(8'h06);
        rd(15'h0010, 1);
        chk_byte(8'h0, {7'h0, u_host.oe_seen});
        u_host.xfer(16, {80'h0, 8'h05, 8'h0}, rx);
        chk_byte(m_st, rx[7:0]);
        backup_busy = 1'b0;
        m_st[0] = 1'b0;
        $display("test busy done");
        op(8'h06);
        u_host.hold_abort(8'h03);
        m_st[1] = 1'b0;
        chk_byte(m_st, device_status_control);
        u_host.xfer(24, {72'h0, 8'ha5, 16'h0}, rx);
        chk_byte(8'h0, {7'h0, u_host.oe_seen});
        $display("test abort and unknown done");
        final_report();
    end
endmodule // tb_spi_sram_write_guard_status
`default_nettype wire
